// [core/pmdi_phy_end.sv]
// PHY end of the MAC data link: clocks, transmit sampling, receive drive
`include "pmdi_regs.svh"

module pmdi_phy_end (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Mode selection
  input wire pmdi_pkg::pmdi_mode_type I_MODE,
  input wire logic I_FAST,
  input wire logic I_FULL_DUPLEX,
  // Receive beats from the line side
  input wire logic I_RX_VALID,
  input wire pmdi_pkg::pmdi_sym_type I_RX_SYM,
  output wire logic O_RX_READY,
  // Transmit beats to the line side
  output wire logic O_TX_VALID,
  output wire pmdi_pkg::pmdi_data_type O_TX_DATA,
  // Pins toward the MAC
  pmdi_if.phy LINK
);
  import pmdi_pkg::*;

  // Whole PHY end state
  typedef struct packed {
    pmdi_mode_type mode; // Mode in force
    logic fast; // 100 Mb/s when high
    logic full; // Full duplex when high
    pmdi_cnt_type cnt; // Position in the link clock period
    logic clk; // Link clock level on the pins
    logic tx_act; // Last sampled transmit enable
    logic tx_valid; // Beat pulse toward the line
    pmdi_data_type tx_data; // Sampled transmit data
    pmdi_rx_state_type rx_st; // Receive framing
    logic rx_dv; // Receive data valid pin
    logic rx_er; // Receive error pin
    logic crs; // Carrier sense pin
    logic col; // Collision pin
    pmdi_data_type rxd; // Receive data pins
  } pmdi_phy_state_type;

  // State after reset: nibble mode, 10 Mb/s, half duplex, link idle
  localparam pmdi_phy_state_type PHY_RST = '{
    mode: PMDI_NIB, fast: 1'b0, full: 1'b0, cnt: '0, clk: 1'b0,
    tx_act: 1'b0, tx_valid: 1'b0, tx_data: '0, rx_st: PMDI_RX_IDLE,
    rx_dv: 1'b0, rx_er: 1'b0, crs: 1'b0, col: 1'b0, rxd: '0};

  pmdi_phy_state_type st_r;
  pmdi_phy_state_type st_nxt;
  pmdi_cnt_type per; // Cycles per link clock period
  pmdi_data_type mask; // Lanes in use
  logic beat; // One reference cycle per link clock period
  logic pop; // Take one receive beat from the buffer
  logic buf_valid; // Buffer holds a beat
  pmdi_sym_type buf_sym; // Oldest buffered beat
  logic err; // Error for the beat being driven

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer: the line side stalls on O_RX_READY, so a beat that
  // arrives while the link clock is slow is held rather than dropped
  pmdi_rx_buf u_rx_buf (
    .i_clk(I_CLK),
    .i_sys_rst(I_SYS_RST),
    .i_in_valid(I_RX_VALID),
    .i_in_data(I_RX_SYM),
    .o_in_ready(O_RX_READY),
    .o_out_valid(buf_valid),
    .o_out_data(buf_sym),
    .i_out_ready(pop)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    per = pmdi_period(st_r.mode, st_r.fast);
    mask = pmdi_mask(st_r.mode);
    pop = 1'b0;
    err = 1'b0;
    st_nxt.full = I_FULL_DUPLEX;

    // Divider from the reference clock; the link clock is high for the
    // first half of the period and low for the rest
    if (st_r.cnt >= pmdi_cnt_type'(per - 1'b1)) begin
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = pmdi_cnt_type'(st_r.cnt + 1'b1);
    end
    // Reduced mode has no link clock: the pins stay low and every
    // reference cycle is a beat
    st_nxt.clk = (st_r.mode != PMDI_RED) &&
                 (st_nxt.cnt < (per >> 1));
    beat = (st_r.cnt == '0);

    // Transmit: sample while the link clock has just gone high; the MAC
    // launched on the fall, so the pins are settled here
    st_nxt.tx_valid = 1'b0;
    if (beat) begin
      st_nxt.tx_act = LINK.tx_en;
      st_nxt.tx_valid = LINK.tx_en;
      st_nxt.tx_data = LINK.txd & mask;
    end

    // Receive: drive once per period; the pins change a cycle after the
    // rise and hold until the next one, where the MAC samples them
    if (beat) begin
      if (buf_valid) begin
        pop = 1'b1;
        st_nxt.rx_st = PMDI_RX_FRAME;
        st_nxt.crs = 1'b1;
        st_nxt.rxd = buf_sym.data & mask;
        case (st_r.mode)
          PMDI_NIB: begin
            // Valid only for real data, error only at 100 Mb/s
            st_nxt.rx_dv = !buf_sym.false_car;
            err = st_r.fast && buf_sym.sym_err;
          end
          PMDI_RED: begin
            st_nxt.rx_dv = !buf_sym.false_car;
            err = (st_r.fast && buf_sym.sym_err) ||
                  buf_sym.false_car;
            // Garbled data lets a MAC that ignores the error pin still
            // reject the frame through its check sequence
            if (err) begin
              st_nxt.rxd = ~buf_sym.data & mask;
            end
          end
          PMDI_SER: begin
            // Framing comes from carrier sense alone
            st_nxt.rx_dv = 1'b0;
          end
          default: begin
            st_nxt.rx_dv = 1'b0;
          end
        endcase
        st_nxt.rx_er = err;
      end else begin
        // Buffer ran dry: the frame ends here
        st_nxt.rx_st = PMDI_RX_IDLE;
        st_nxt.crs = 1'b0;
        st_nxt.rx_dv = 1'b0;
        st_nxt.rx_er = 1'b0;
        st_nxt.rxd = '0;
      end
    end

    // Collision: both directions active, half duplex only
    case (st_nxt.rx_st)
      PMDI_RX_FRAME: st_nxt.col = !st_r.full && st_nxt.tx_act;
      PMDI_RX_IDLE: st_nxt.col = 1'b0;
      default: st_nxt.col = 1'b0;
    endcase

    // A new mode or speed restarts the link from idle, so no beat is
    // framed half in one mode and half in the other
    if ((I_MODE != st_r.mode) || (I_FAST != st_r.fast)) begin
      st_nxt = PHY_RST;
      st_nxt.mode = I_MODE;
      st_nxt.fast = I_FAST;
      st_nxt.full = I_FULL_DUPLEX;
      pop = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_r <= PHY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins and line side outputs, all straight from the state register
  assign LINK.tx_clk = st_r.clk;
  assign LINK.rx_clk = st_r.clk;
  assign LINK.rx_dv = st_r.rx_dv;
  assign LINK.rx_er = st_r.rx_er;
  assign LINK.crs = st_r.crs;
  assign LINK.col = st_r.col;
  assign LINK.rxd = st_r.rxd;
  assign O_TX_VALID = st_r.tx_valid;
  assign O_TX_DATA = st_r.tx_data;
endmodule : pmdi_phy_end

// [core/pmdi_regs.svh]
// Timing, width and mask constants for the PHY to MAC data link
`ifndef PMDI_REGS_SVH
`define PMDI_REGS_SVH

// Reference clock rate, also the reduced two-bit mode clock
`define PMDI_REF_KHZ 50000
// Nibble mode clock at 100 Mb/s
`define PMDI_NIB100_KHZ 25000
// Nibble mode clock at 10 Mb/s
`define PMDI_NIB10_KHZ 2500
// Serial ten meg mode clock
`define PMDI_SER_KHZ 10000

// Width of the clock divider counter
`define PMDI_CNT_W 5
// Width of one data beat on the pins
`define PMDI_DATA_W 4

// Data lane masks per mode
`define PMDI_MASK_NIB 4'hF
`define PMDI_MASK_RED 4'h3
`define PMDI_MASK_SER 4'h1

// Entries held by the receive buffer
`define PMDI_BUF_FULL 2'h2

`endif

// [core/pmdi_pkg.sv]
// Shared types and mode decoding for the PHY to MAC data link
package pmdi_pkg;
  `include "pmdi_regs.svh"

  // Interface mode, one-hot
  typedef enum logic [2:0] {
    PMDI_NIB = 3'h1,
    PMDI_RED = 3'h2,
    PMDI_SER = 3'h4
  } pmdi_mode_type;

  // Receive framing state of the PHY end, one-hot
  typedef enum logic [1:0] {
    PMDI_RX_IDLE = 2'h1,
    PMDI_RX_FRAME = 2'h2
  } pmdi_rx_state_type;

  typedef logic [`PMDI_CNT_W-1:0] pmdi_cnt_type;
  typedef logic [`PMDI_DATA_W-1:0] pmdi_data_type;

  // One received line beat with its error flags
  typedef struct packed {
    pmdi_data_type data;
    logic sym_err;
    logic false_car;
  } pmdi_sym_type;

  // Reference cycles per link clock period in the given mode
  function automatic pmdi_cnt_type pmdi_period(pmdi_mode_type m,
                                               logic fast);
    int unsigned khz;
    case (m)
      PMDI_NIB: khz = fast ? `PMDI_NIB100_KHZ : `PMDI_NIB10_KHZ;
      PMDI_SER: khz = `PMDI_SER_KHZ;
      default: khz = `PMDI_REF_KHZ;
    endcase
    return pmdi_cnt_type'(`PMDI_REF_KHZ / khz);
  endfunction : pmdi_period

  // Data lanes in use in the given mode
  function automatic pmdi_data_type pmdi_mask(pmdi_mode_type m);
    case (m)
      PMDI_NIB: return `PMDI_MASK_NIB;
      PMDI_RED: return `PMDI_MASK_RED;
      default: return `PMDI_MASK_SER;
    endcase
  endfunction : pmdi_mask
endpackage : pmdi_pkg

// [core/pmdi_if.sv]
// Pin bundle between the PHY end and the MAC end of the data link
interface pmdi_if;
  logic tx_clk; // Transmit clock from the PHY
  logic rx_clk; // Receive clock from the PHY
  logic tx_en; // Transmit enable from the MAC
  logic [3:0] txd; // Transmit data from the MAC
  logic rx_dv; // Receive data valid
  logic rx_er; // Receive error
  logic crs; // Carrier sense, or carrier sense data valid
  logic col; // Collision
  logic [3:0] rxd; // Receive data

  // PHY side
  modport phy (
    output tx_clk, rx_clk, rx_dv, rx_er, crs, col, rxd,
    input tx_en, txd
  );

  // MAC side
  modport mac (
    input tx_clk, rx_clk, rx_dv, rx_er, crs, col, rxd,
    output tx_en, txd
  );
endinterface : pmdi_if

// [core/pmdi_rx_buf.sv]
// Two-entry receive buffer with valid and ready on both sides
`include "pmdi_regs.svh"

module pmdi_rx_buf (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Filling side
  input wire logic i_in_valid,
  input wire pmdi_pkg::pmdi_sym_type i_in_data,
  output wire logic o_in_ready,
  // Draining side
  output wire logic o_out_valid,
  output wire pmdi_pkg::pmdi_sym_type o_out_data,
  input wire logic i_out_ready
);
  import pmdi_pkg::*;

  // Whole buffer state
  typedef struct packed {
    pmdi_sym_type [1:0] mem; // Storage
    logic wr; // Write slot
    logic rd; // Read slot
    logic [1:0] cnt; // Entries held
    logic rdy; // Registered ready, so the source sees a flop
  } pmdi_buf_state_type;

  pmdi_buf_state_type st_r;
  pmdi_buf_state_type st_nxt;
  logic push;
  logic pop;

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    push = i_in_valid && st_r.rdy;
    pop = i_out_ready && (st_r.cnt != 2'h0);
    // Store on push
    if (push) begin
      st_nxt.mem[st_r.wr] = i_in_data;
      st_nxt.wr = ~st_r.wr;
    end
    // Advance on pop
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    // Occupancy
    case ({push, pop})
      2'b10: st_nxt.cnt = 2'(st_r.cnt + 2'h1);
      2'b01: st_nxt.cnt = 2'(st_r.cnt - 2'h1);
      default: st_nxt.cnt = st_r.cnt;
    endcase
    // Ready drops only when both slots are taken, so nothing is lost
    st_nxt.rdy = (st_nxt.cnt != `PMDI_BUF_FULL);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '{mem: '0, wr: 1'b0, rd: 1'b0, cnt: 2'h0, rdy: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_in_ready = st_r.rdy;
  assign o_out_valid = (st_r.cnt != 2'h0);
  assign o_out_data = st_r.mem[st_r.rd];
endmodule : pmdi_rx_buf

// [core/pmdi_mac_end.sv]
// MAC end of the data link: launches transmit, samples receive
`include "pmdi_regs.svh"

module pmdi_mac_end (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Mode selection
  input wire pmdi_pkg::pmdi_mode_type I_MODE,
  // Transmit words from the user
  input wire logic I_TX_VALID,
  input wire pmdi_pkg::pmdi_data_type I_TX_DATA,
  output wire logic O_TX_READY,
  // Receive words to the user
  output wire logic O_RX_VALID,
  output wire pmdi_pkg::pmdi_data_type O_RX_DATA,
  output wire logic O_RX_ERR,
  output wire logic O_COL,
  // Pins toward the PHY
  pmdi_if.mac LINK
);
  import pmdi_pkg::*;

  // Whole MAC end state
  typedef struct packed {
    pmdi_mode_type mode; // Mode in force
    logic tclk_q; // Transmit clock one cycle ago
    logic rclk_q; // Receive clock one cycle ago
    logic ready; // Launch slot open this cycle
    logic tx_en; // Transmit enable pin
    pmdi_data_type txd; // Transmit data pins
    logic rx_valid; // Received word pulse
    pmdi_data_type rx_data; // Received word
    logic rx_err; // Error with the word
    logic col; // Collision seen at the last sample
  } pmdi_mac_state_type;

  pmdi_mac_state_type st_r;
  pmdi_mac_state_type st_nxt;
  logic red; // Reduced mode: every cycle is a beat
  logic samp; // Receive sample point

  //////////////////////////////////////////////////////////////////////////
  // Next state; the PHY pins come from flops on the same clock, so they
  // are read without synchronisers
  always_comb begin
    st_nxt = st_r;
    st_nxt.mode = I_MODE;
    red = (st_r.mode == PMDI_RED);
    st_nxt.tclk_q = LINK.tx_clk;
    st_nxt.rclk_q = LINK.rx_clk;

    // Open a launch slot after each fall of the transmit clock, so the
    // pins settle well before the PHY samples at the next rise
    st_nxt.ready = red || (st_r.tclk_q && !LINK.tx_clk);
    if (st_r.ready) begin
      // Enable tracks data exactly; a slot with no word idles the pins
      st_nxt.tx_en = I_TX_VALID;
      st_nxt.txd = I_TX_VALID ? (I_TX_DATA & pmdi_mask(st_r.mode)) : '0;
    end

    // Receive sample on each rise, or every cycle in reduced mode
    samp = red || (!st_r.rclk_q && LINK.rx_clk);
    st_nxt.rx_valid = 1'b0;
    if (samp) begin
      case (st_r.mode)
        PMDI_NIB: st_nxt.rx_valid = LINK.rx_dv;
        PMDI_RED: st_nxt.rx_valid = LINK.crs;
        PMDI_SER: st_nxt.rx_valid = LINK.crs;
        default: st_nxt.rx_valid = 1'b0;
      endcase
      st_nxt.rx_data = LINK.rxd & pmdi_mask(st_r.mode);
      st_nxt.rx_err = (st_r.mode != PMDI_SER) && LINK.rx_er;
      st_nxt.col = LINK.col;
    end

    // A mode change drops any half-launched word
    if (I_MODE != st_r.mode) begin
      st_nxt.ready = 1'b0;
      st_nxt.tx_en = 1'b0;
      st_nxt.txd = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_r <= '{mode: PMDI_NIB, tclk_q: 1'b0, rclk_q: 1'b0, ready: 1'b0,
                tx_en: 1'b0, txd: '0, rx_valid: 1'b0, rx_data: '0,
                rx_err: 1'b0, col: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign LINK.tx_en = st_r.tx_en;
  assign LINK.txd = st_r.txd;
  assign O_TX_READY = st_r.ready;
  assign O_RX_VALID = st_r.rx_valid;
  assign O_RX_DATA = st_r.rx_data;
  assign O_RX_ERR = st_r.rx_err;
  assign O_COL = st_r.col;
endmodule : pmdi_mac_end

// [testbench/pmdi_monitor.sv]
// Pin level checker for the PHY to MAC data link
module pmdi_monitor (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Mode of the PHY end
  input wire pmdi_pkg::pmdi_mode_type I_MODE,
  input wire logic I_FAST,
  input wire logic I_FULL_DUPLEX,
  // Link pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic crs,
  input wire logic col,
  input wire logic [3:0] rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmdi_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] settle_r; // Cycles since reset release, saturating
  logic ok; // Mode restart is over
  logic nib; // Nibble mode active
  logic red; // Reduced two-bit mode active
  logic ser; // Serial ten meg mode active

  // The PHY may restart one cycle after release, so checks wait a little
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      settle_r <= 3'h0;
    end else if (!ok) begin
      settle_r <= settle_r + 3'h1;
    end
  end
  assign ok = (settle_r == 3'h7);
  assign nib = ok && (I_MODE == PMDI_NIB);
  assign red = ok && (I_MODE == PMDI_RED);
  assign ser = ok && (I_MODE == PMDI_SER);

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  ////////////////////////////////////////////////////////////////////////////
  // One link clock period, high phase first
  sequence s_fast_period;
    tx_clk ##1 !tx_clk ##1 tx_clk;
  endsequence
  sequence s_slow_period;
    tx_clk[*8] ##1 tx_clk[*2] ##1 !tx_clk[*8] ##1 !tx_clk[*2] ##1 tx_clk;
  endsequence
  sequence s_ser_period;
    tx_clk[*2] ##1 !tx_clk[*3] ##1 tx_clk;
  endsequence

  AST_NIB_FAST_CLK: assert property (
    nib && I_FAST && $rose(tx_clk) |-> s_fast_period)
    else $error("nibble fast clock period wrong");
  AST_NIB_SLOW_CLK: assert property (
    nib && !I_FAST && $rose(tx_clk) |-> s_slow_period)
    else $error("nibble slow clock period wrong");
  AST_SER_CLK: assert property (
    ser && $rose(tx_clk) |-> s_ser_period)
    else $error("serial clock period wrong");
  AST_RX_CLK_SAME: assert property (ok |-> rx_clk == tx_clk)
    else $error("receive clock differs from transmit clock");
  AST_RED_CLK_IDLE: assert property (red |-> !tx_clk && !rx_clk)
    else $error("link clock toggles in reduced mode");
  AST_PIN_HOLD: assert property (
    (nib || ser) && $rose(tx_clk) |-> $stable(rxd) && $stable(crs))
    else $error("receive pins move at the clock rise");
  AST_MAC_LAUNCH: assert property (
    (nib || ser) && ($changed(tx_en) || $changed(txd)) |-> !tx_clk)
    else $error("transmit pins move while clock high");
  AST_NIB_IDLE: assert property (
    nib && !rx_dv |-> !rx_er && !crs && rxd == 4'h0)
    else $error("receive pins busy without data valid");
  AST_NIB_SLOW_ERR: assert property (nib && !I_FAST |-> !rx_er)
    else $error("receive error at 10 Mb/s");
  AST_RED_LANES: assert property (red |-> rxd[3:2] == 2'h0)
    else $error("unused reduced lanes driven");
  AST_RED_ERR_CRS: assert property (red && rx_er |-> crs)
    else $error("reduced error outside carrier");
  AST_SER_UNUSED: assert property (
    ser |-> !rx_dv && !rx_er && rxd[3:1] == 3'h0)
    else $error("unused serial pins driven");
  AST_COL_FULL: assert property (ok && I_FULL_DUPLEX |-> !col)
    else $error("collision in full duplex");
endmodule : pmdi_monitor

// [testbench/tb.sv]
// Self-checking bench joining the PHY end and the MAC end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmdi_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic clk, rst, fast, full, rx_valid, tx_valid, running;
  pmdi_mode_type mode;
  pmdi_sym_type rx_sym;
  pmdi_data_type tx_data, phy_tx_data, mac_rx_data;
  logic phy_rx_ready, phy_tx_valid, mac_tx_ready, mac_rx_valid;
  logic mac_rx_err, mac_col, col_seen, saw_full;
  int failures, samples_checked, cycles;
  logic [31:0] seed; // Xorshift state
  logic [4:0] rx_q[$]; // Expected {data, error} at the MAC
  pmdi_data_type tx_q[$]; // Expected beats at the PHY

  pmdi_if u_pmdi_if();
  pmdi_phy_end u_pmdi_phy_end (.I_CLK(clk), .I_SYS_RST(rst), .I_MODE(mode),
    .I_FAST(fast), .I_FULL_DUPLEX(full), .I_RX_VALID(rx_valid),
    .I_RX_SYM(rx_sym), .O_RX_READY(phy_rx_ready), .O_TX_VALID(phy_tx_valid),
    .O_TX_DATA(phy_tx_data), .LINK(u_pmdi_if));
  pmdi_mac_end u_pmdi_mac_end (.I_CLK(clk), .I_SYS_RST(rst), .I_MODE(mode),
    .I_TX_VALID(tx_valid), .I_TX_DATA(tx_data), .O_TX_READY(mac_tx_ready),
    .O_RX_VALID(mac_rx_valid), .O_RX_DATA(mac_rx_data),
    .O_RX_ERR(mac_rx_err), .O_COL(mac_col), .LINK(u_pmdi_if));
  pmdi_monitor u_pmdi_monitor (.I_CLK(clk), .I_SYS_RST(rst), .I_MODE(mode),
    .I_FAST(fast), .I_FULL_DUPLEX(full), .tx_clk(u_pmdi_if.tx_clk),
    .rx_clk(u_pmdi_if.rx_clk), .tx_en(u_pmdi_if.tx_en),
    .txd(u_pmdi_if.txd), .rx_dv(u_pmdi_if.rx_dv), .rx_er(u_pmdi_if.rx_er),
    .crs(u_pmdi_if.crs), .col(u_pmdi_if.col), .rxd(u_pmdi_if.rxd));
  ////////////////////////////////////////////////////////////////////////////
  // Repeatable random source
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  // Lanes carried in each mode
  function automatic pmdi_data_type lanes(pmdi_mode_type m);
    if (m == PMDI_NIB) return 4'hF;
    if (m == PMDI_RED) return 4'h3;
    return 4'h1;
  endfunction : lanes

  // What the MAC user should see for one line beat
  function automatic logic [4:0] exp_rx(pmdi_sym_type s);
    logic err;
    pmdi_data_type d;
    err = (mode == PMDI_SER) ? 1'b0 : (fast & s.sym_err);
    if (mode == PMDI_RED) begin
      err = err | s.false_car;
    end
    d = (mode == PMDI_RED && err) ? ~s.data : s.data;
    return {d & lanes(mode), err};
  endfunction : exp_rx

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard; a full run needs under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // Output pulses last one cycle, so look at every falling edge
  always @(negedge clk) begin
    if (running && phy_tx_valid === 1'b1) begin
      if (tx_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
      else check(phy_tx_data, tx_q.pop_front());
    end
    if (running && mac_rx_valid === 1'b1) begin
      if (rx_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
      else check({mac_rx_data, mac_rx_err}, rx_q.pop_front());
    end
    if (mac_col === 1'b1) col_seen = 1'b1;
    if (phy_rx_ready === 1'b0) saw_full = 1'b1;
  end

  // Line beats; ready seen at a falling edge holds through the next rise
  task automatic feed_rx(input int n);
    int k;
    logic [31:0] r;
    k = 0;
    while (k < n) begin
      r = next_rand();
      rx_sym.data = r[3:0];
      rx_sym.sym_err = r[4];
      rx_sym.false_car = (mode == PMDI_RED) && r[5] && r[6];
      rx_valid = (r[9:8] != 2'h0);
      if (rx_valid) begin
        while (phy_rx_ready !== 1'b1) @(negedge clk);
        rx_q.push_back(exp_rx(rx_sym));
        k++;
      end
      @(negedge clk);
    end
    rx_valid = 1'b0;
  endtask : feed_rx

  // User words into the MAC, held until a launch slot takes them
  task automatic feed_tx(input int n);
    int k;
    logic [31:0] r;
    k = 0;
    while (k < n) begin
      r = next_rand();
      tx_data = r[13:10];
      tx_valid = (r[15:14] != 2'h0);
      if (tx_valid) begin
        while (mac_tx_ready !== 1'b1) @(negedge clk);
        tx_q.push_back(tx_data & lanes(mode));
        k++;
      end
      @(negedge clk);
    end
    tx_valid = 1'b0;
  endtask : feed_tx

  // Mode is only changed under reset, then traffic flows both ways
  task automatic run_cfg(input pmdi_mode_type m, input logic f,
                         input logic fd, input int n);
    int w;
    @(negedge clk);
    rst = 1'b1;
    running = 1'b0;
    mode = m;
    fast = f;
    full = fd;
    rx_q.delete();
    tx_q.delete();
    repeat (5) @(negedge clk);
    rst = 1'b0;
    col_seen = 1'b0;
    saw_full = 1'b0;
    running = 1'b1;
    repeat (2) @(negedge clk);
    fork
      feed_rx(n);
      feed_tx(n);
    join
    w = 0;
    while ((rx_q.size() != 0 || tx_q.size() != 0) && w < 300) begin
      @(negedge clk);
      w++;
    end
    check(rx_q.size(), 0);
    check(tx_q.size(), 0);
    check(col_seen, !fd);
    if (m == PMDI_NIB && !f) check(saw_full, 1);
  endtask : run_cfg

  // Main sequence: every mode, both speeds where they matter
  initial begin
    pmdi_mode_type cm[5];
    cm = '{PMDI_NIB, PMDI_NIB, PMDI_RED, PMDI_RED, PMDI_SER};
    seed = 32'h0001_64AB;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'b1;
    running = 1'b0;
    mode = PMDI_NIB;
    fast = 1'b0;
    full = 1'b0;
    rx_valid = 1'b0;
    rx_sym = '0;
    tx_valid = 1'b0;
    tx_data = 4'h0;
    col_seen = 1'b0;
    saw_full = 1'b0;
    for (int i = 0; i < 5; i++) begin
      run_cfg(cm[i], 1'(5'h05 >> i), 1'(5'h06 >> i), 24);
    end
    report_and_stop();
  end
endmodule : tb
